/* File: rtl/islc_ctrl.sv */
// islc_ctrl: control and status registers of the s/t line interface.
// assumes: host port with one-cycle strobes, read data one cycle later;
// line-side events arrive as one-cycle pulses on the core clock.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module islc_ctrl
(
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   // host register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // line unit status
   input  wire logic       in_f6_f7_i,
   input  wire logic       mf_found_i,
   input  wire logic       mf_bad_i,
   input  wire logic       mf_frame_i,
   input  wire logic [4:0] s_bits_i,
   input  wire logic       q_taken_i,
   input  wire logic       echo_stb_i,
   input  wire logic       echo_bit_i,
   input  wire logic       pkt_ok_i,
   input  wire logic       d_access_i,
   input  wire logic       d_mismatch_i,
   // line unit controls
   output logic            b1_tx_en_o,
   output logic            b2_tx_en_o,
   output logic            f_tx_off_o,
   output logic            fa_tx_off_o,
   output logic            act_req_o,
   output logic            timer_expiry_o,
   output logic            f8_to_f3_o,
   output logic            line_en_o,
   output logic            remote_loop_o,
   output logic            local_loop_o,
   output logic            host_tx_block_o,
   output logic            line_d_ignore_o,
   output logic            halt_tx_o,
   output logic            d_clear_o,
   output logic [3:0]      ie_line_o,
   output logic            q_bit_o,
   output logic [3:0]      q_pattern_o,
   output logic            mf_synced_o,
   output logic            mf_irq_o
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [3:0] prio_r;
   logic [6:0] mode1_r;
   logic [6:0] mode2_r;
   logic [4:0] mfc_r;
   logic       synced_r;
   logic [7:0] stat_r;
   logic [7:0] stat_nxt;
   logic [4:0] qbuf_r;
   logic [1:0] bad_cnt_r;
   logic [1:0] bad_cnt_nxt;
   logic       synced_nxt;
   logic       act_prev_r;
   logic [7:0] rdata_nxt;
   logic       d_clear_w;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire wr_prio  = wr_i && (addr_i == islc_pkg::ADDR_PRIORITY);
   wire wr_mode1 = wr_i && (addr_i == islc_pkg::ADDR_MODE_ONE);
   wire wr_mode2 = wr_i && (addr_i == islc_pkg::ADDR_MODE_TWO);
   wire wr_mfc   = wr_i && (addr_i == islc_pkg::ADDR_MF_CTRL);
   wire wr_qbuf  = wr_i && (addr_i == islc_pkg::ADDR_MF_QBUF);
   wire rd_stat  = rd_i && (addr_i == islc_pkg::ADDR_MF_STAT);

   wire [7:0] wd_prio = wdata_i & islc_pkg::MASK_PRIORITY;
   wire [7:0] wd_mode = wdata_i & islc_pkg::MASK_MODE;
   wire [7:0] wd_mfc  = wdata_i & islc_pkg::MASK_MF_CTRL;

   // read mux; unmapped and write-only addresses read zero
   always_comb
   begin
      rdata_nxt = islc_pkg::RST_ZERO;
      if (addr_i == islc_pkg::ADDR_PRIORITY)
         rdata_nxt = {4'h0, prio_r};
      else if (addr_i == islc_pkg::ADDR_MODE_ONE)
         rdata_nxt = {1'b0, mode1_r};
      else if (addr_i == islc_pkg::ADDR_MODE_TWO)
         rdata_nxt = {1'b0, mode2_r};
      else if (addr_i == islc_pkg::ADDR_MF_CTRL)
         rdata_nxt = {synced_r, 2'b00, mfc_r};
      else if (addr_i == islc_pkg::ADDR_MF_STAT)
         rdata_nxt = stat_r;
   end

   // ---------------------------------------------------------------
   // multiframe synchronisation
   // ---------------------------------------------------------------
   wire sync_en  = mfc_r[islc_pkg::MF_SYNC_EN];
   wire bad_lim  = (bad_cnt_r == 2'(islc_pkg::BAD_MF_LIMIT - 1));
   wire lose     = synced_r && (!sync_en || !in_f6_f7_i
                 || (mf_bad_i && bad_lim));
   wire gain     = !synced_r && sync_en && in_f6_f7_i && mf_found_i;

   always_comb
   begin
      synced_nxt  = synced_r;
      bad_cnt_nxt = bad_cnt_r;
      if (lose)
      begin
         synced_nxt  = 1'b0;
         bad_cnt_nxt = 2'b00;
      end
      else if (gain)
      begin
         synced_nxt  = 1'b1;
         bad_cnt_nxt = 2'b00;
      end
      else if (synced_r && mf_bad_i)
         bad_cnt_nxt = bad_cnt_r + 2'b01;
      else if (synced_r && mf_frame_i)
         bad_cnt_nxt = 2'b00;
   end

   // ---------------------------------------------------------------
   // status buffer: events win over the clearing read
   // ---------------------------------------------------------------
   wire s_new = synced_r && mf_frame_i && !mf_bad_i;
   always_comb
   begin
      stat_nxt = stat_r;
      if (rd_stat)
      begin
         stat_nxt[islc_pkg::ST_SDATA]  = 1'b0;
         stat_nxt[islc_pkg::ST_QEMPTY] = 1'b0;
         stat_nxt[islc_pkg::ST_CHG]    = 1'b0;
      end
      if (s_new)
      begin
         stat_nxt[4:0]                = s_bits_i;
         stat_nxt[islc_pkg::ST_SDATA] = 1'b1;
      end
      if (q_taken_i && synced_r)
         stat_nxt[islc_pkg::ST_QEMPTY] = 1'b1;
      if (lose || gain)
         stat_nxt[islc_pkg::ST_CHG] = 1'b1;
   end

   // gated interrupt request from the three status flags
   wire irq_nxt = (stat_r[islc_pkg::ST_SDATA]
                   && mfc_r[islc_pkg::MF_IE_SDATA])
               || (stat_r[islc_pkg::ST_QEMPTY]
                   && mfc_r[islc_pkg::MF_IE_QEMPTY])
               || (stat_r[islc_pkg::ST_CHG]
                   && mfc_r[islc_pkg::MF_IE_CHG]);

   // ---------------------------------------------------------------
   // d-channel priority counting
   // ---------------------------------------------------------------
   islc_prio_count islc_prio_count_i
   (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .level_i    (prio_r),
      .echo_stb_i (echo_stb_i),
      .echo_bit_i (echo_bit_i),
      .pkt_ok_i   (pkt_ok_i),
      .access_i   (d_access_i),
      .clear_o    (d_clear_w)
   );

   wire loop_rem = mode2_r[islc_pkg::M2_REM_LOOP];
   wire mis_ok   = loop_rem || mode2_r[islc_pkg::M2_NO_BACKOF];
   wire act_now  = mode1_r[islc_pkg::M1_ACT_REQ];

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prio_r     <= 4'h0;
         mode1_r    <= 7'h00;
         mode2_r    <= 7'h00;
         mfc_r      <= 5'h00;
         qbuf_r     <= islc_pkg::RST_QBUF;
         stat_r     <= islc_pkg::RST_MF_STAT;
         synced_r   <= 1'b0;
         bad_cnt_r  <= 2'b00;
         act_prev_r <= 1'b0;
      end
      else
      begin
         if (wr_prio)
            prio_r <= wd_prio[3:0];
         if (wr_mode1)
            mode1_r <= wd_mode[6:0];
         if (wr_mode2)
            mode2_r <= wd_mode[6:0];
         if (wr_mfc)
            mfc_r <= wd_mfc[4:0];
         if (wr_qbuf)
            qbuf_r <= wdata_i[4:0];
         stat_r     <= stat_nxt;
         synced_r   <= synced_nxt;
         bad_cnt_r  <= bad_cnt_nxt;
         act_prev_r <= act_now;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_o         <= 8'h00;
         b1_tx_en_o      <= 1'b0;
         b2_tx_en_o      <= 1'b0;
         f_tx_off_o      <= 1'b0;
         fa_tx_off_o     <= 1'b0;
         act_req_o       <= 1'b0;
         timer_expiry_o  <= 1'b0;
         f8_to_f3_o      <= 1'b0;
         line_en_o       <= 1'b0;
         remote_loop_o   <= 1'b0;
         local_loop_o    <= 1'b0;
         host_tx_block_o <= 1'b0;
         line_d_ignore_o <= 1'b0;
         halt_tx_o       <= 1'b0;
         d_clear_o       <= 1'b0;
         ie_line_o       <= 4'h0;
         q_bit_o         <= 1'b0;
         q_pattern_o     <= 4'h0;
         mf_synced_o     <= 1'b0;
         mf_irq_o        <= 1'b0;
      end
      else
      begin
         rdata_o         <= rd_i ? rdata_nxt : islc_pkg::RST_ZERO;
         b1_tx_en_o      <= mode1_r[islc_pkg::M1_B1_EN];
         b2_tx_en_o      <= mode1_r[islc_pkg::M1_B2_EN];
         f_tx_off_o      <= mode1_r[islc_pkg::M1_F_OFF];
         fa_tx_off_o     <= mode1_r[islc_pkg::M1_FA_OFF];
         act_req_o       <= act_now;
         timer_expiry_o  <= act_prev_r && !act_now;
         f8_to_f3_o      <= mode1_r[islc_pkg::M1_F8_TO_F3];
         line_en_o       <= mode1_r[islc_pkg::M1_LINE_EN];
         remote_loop_o   <= loop_rem;
         local_loop_o    <= mode2_r[islc_pkg::M2_LOC_LOOP];
         host_tx_block_o <= loop_rem;
         line_d_ignore_o <= mode2_r[islc_pkg::M2_LOC_LOOP];
         halt_tx_o       <= d_mismatch_i && !mis_ok;
         d_clear_o       <= d_clear_w;
         ie_line_o       <= {mode2_r[islc_pkg::M2_IE_F7],
                             mode2_r[islc_pkg::M2_IE_HOOK],
                             mode2_r[islc_pkg::M2_IE_F8],
                             mode2_r[islc_pkg::M2_IE_F3]};
         // unsync value in all q bits until synchronised
         q_bit_o         <= qbuf_r[islc_pkg::QB_UNSYNC];
         q_pattern_o     <= (sync_en && synced_r) ? qbuf_r[3:0]
                            : {4{qbuf_r[islc_pkg::QB_UNSYNC]}};
         mf_synced_o     <= synced_r;
         mf_irq_o        <= irq_nxt;
      end
   end

endmodule // islc_ctrl

/* File: common/islc_pkg.sv */
// islc_pkg: register map, field positions, reset values and counting
// constants for the line interface control block.
// assumes: a byte-wide indirect register port on the device clock.
package islc_pkg;

   // ---------------------------------------------------------------
   // register offsets (indirect addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_PRIORITY  = 8'hA2;
   localparam logic [7:0] ADDR_MODE_ONE  = 8'hA3;
   localparam logic [7:0] ADDR_MODE_TWO  = 8'hA4;
   localparam logic [7:0] ADDR_MF_CTRL   = 8'hA6;
   localparam logic [7:0] ADDR_MF_STAT   = 8'hA7;
   localparam logic [7:0] ADDR_MF_QBUF   = 8'hA8;

   // ---------------------------------------------------------------
   // reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_MF_STAT    = 8'h40;
   localparam logic [4:0] RST_QBUF       = 5'h0F;
   localparam logic [7:0] MASK_PRIORITY  = 8'h0F;
   localparam logic [7:0] MASK_MODE      = 8'h7F;
   localparam logic [7:0] MASK_MF_CTRL   = 8'h1F;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int M1_B1_EN     = 0;
   localparam int M1_B2_EN     = 1;
   localparam int M1_F_OFF     = 2;
   localparam int M1_FA_OFF    = 3;
   localparam int M1_ACT_REQ   = 4;
   localparam int M1_F8_TO_F3  = 5;
   localparam int M1_LINE_EN   = 6;
   localparam int M2_REM_LOOP  = 0;
   localparam int M2_LOC_LOOP  = 1;
   localparam int M2_NO_BACKOF = 2;
   localparam int M2_IE_F3     = 3;
   localparam int M2_IE_F8     = 4;
   localparam int M2_IE_HOOK   = 5;
   localparam int M2_IE_F7     = 6;
   localparam int MF_SYNC_EN   = 0;
   localparam int MF_IE_SDATA  = 1;
   localparam int MF_IE_QEMPTY = 2;
   localparam int MF_IE_CHG    = 3;
   localparam int MF_FIRST_SUB = 4;
   localparam int MF_SYNCED    = 7;
   localparam int ST_SDATA     = 5;
   localparam int ST_QEMPTY    = 6;
   localparam int ST_CHG       = 7;
   localparam int QB_UNSYNC    = 4;

   // ---------------------------------------------------------------
   // access priority counting and multiframe sync loss limit
   // ---------------------------------------------------------------
   localparam logic [4:0] PRIO_BASE_ONES = 5'h08;
   localparam int         BAD_MF_LIMIT   = 3;

endpackage : islc_pkg

/* File: rtl/islc_prio_count.sv */
// islc_prio_count: echo-channel ones counter gating d-channel access.
// assumes: echo bit strobe is a one-cycle enable on the core clock.
`timescale 1ns/100ps
module islc_prio_count
(
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic [3:0] level_i,
   input  wire logic       echo_stb_i,
   input  wire logic       echo_bit_i,
   input  wire logic       pkt_ok_i,
   input  wire logic       access_i,
   output logic            clear_o
);

   logic       raised_r;
   logic       raised_nxt;
   logic [5:0] ones_r;
   logic [5:0] ones_nxt;
   logic [5:0] need_w;
   logic [4:0] eff_w;

   // ---------------------------------------------------------------
   // required ones: 8 + 2 * effective level
   // ---------------------------------------------------------------
   assign eff_w  = {1'b0, level_i} + {4'h0, raised_r};
   assign need_w = {1'b0, islc_pkg::PRIO_BASE_ONES}
                 + {eff_w, 1'b0};
   assign clear_o = (ones_r >= need_w);

   always_comb
   begin
      ones_nxt   = ones_r;
      raised_nxt = raised_r;
      if (echo_stb_i)
      begin
         // a zero in the echo restarts the count
         if (!echo_bit_i)
            ones_nxt = 6'h00;
         else if (!clear_o)
            ones_nxt = ones_r + 6'h01;
      end
      if (access_i)
      begin
         ones_nxt = 6'h00;
         if (raised_r)
            raised_nxt = 1'b0;
      end
      if (pkt_ok_i)
         raised_nxt = 1'b1;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ones_r   <= 6'h00;
         raised_r <= 1'b0;
      end
      else
      begin
         ones_r   <= ones_nxt;
         raised_r <= raised_nxt;
      end
   end

endmodule // islc_prio_count

/* File: test/islc_ctrl_monitor.sv */
// islc_ctrl_monitor: port assertions for the line interface control.
// assumes: bound to islc_ctrl, one clock, async active-low reset.
`timescale 1ns/100ps
module islc_ctrl_monitor
(
   input wire logic       core_clk_i,
   input wire logic       rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       b1_tx_en_o,
   input wire logic       b2_tx_en_o,
   input wire logic       f_tx_off_o,
   input wire logic       fa_tx_off_o,
   input wire logic       act_req_o,
   input wire logic       timer_expiry_o,
   input wire logic       f8_to_f3_o,
   input wire logic       line_en_o,
   input wire logic       remote_loop_o,
   input wire logic       local_loop_o,
   input wire logic       host_tx_block_o,
   input wire logic       line_d_ignore_o,
   input wire logic       halt_tx_o,
   input wire logic [3:0] ie_line_o,
   input wire logic       q_bit_o,
   input wire logic [3:0] q_pattern_o,
   input wire logic       mf_synced_o
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   chk_rdata_idle_zero:
      assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data seen outside read slot");
   chk_qbuf_reads_zero:
      assert property ($past(rd_i && addr_i == islc_pkg::ADDR_MF_QBUF)
         |-> rdata_o == 8'h00) else $error("q buffer readable");
   chk_prio_upper_zero:
      assert property ($past(rd_i && addr_i == islc_pkg::ADDR_PRIORITY)
         |-> rdata_o[7:4] == 4'h0) else $error("priority upper bits set");
   chk_mode_one_out:
      assert property ($past(wr_i && addr_i == islc_pkg::ADDR_MODE_ONE, 2)
         |-> {1'b0, line_en_o, f8_to_f3_o, act_req_o, fa_tx_off_o,
              f_tx_off_o, b2_tx_en_o, b1_tx_en_o}
             == ($past(wdata_i, 2) & 8'h7F))
      else $error("mode one outputs differ from write");
   chk_mode_two_out:
      assert property ($past(wr_i && addr_i == islc_pkg::ADDR_MODE_TWO, 2)
         |-> {1'b0, ie_line_o, 1'b0, local_loop_o, remote_loop_o}
             == ($past(wdata_i, 2) & 8'h7B))
      else $error("mode two outputs differ from write");
   chk_timer_pulse:
      assert property ($fell(act_req_o) == timer_expiry_o)
      else $error("expiry pulse not tied to request fall");
   chk_loop_pairs:
      assert property (host_tx_block_o == remote_loop_o
         && line_d_ignore_o == local_loop_o)
      else $error("loopback side effects out of step");
   chk_loop_write:
      assert property ($past(wr_i && addr_i == islc_pkg::ADDR_MODE_TWO, 2)
         |-> {line_d_ignore_o, host_tx_block_o} == $past(wdata_i[1:0], 2))
      else $error("loopback controls differ from write");
   chk_remote_no_halt:
      assert property (remote_loop_o |-> !halt_tx_o)
      else $error("halt during remote loopback");
   chk_unsync_q_fill:
      assert property (!mf_synced_o |-> q_pattern_o == {4{q_bit_o}})
      else $error("q pattern not filled while unsynced");
endmodule // islc_ctrl_monitor

bind islc_ctrl islc_ctrl_monitor islc_ctrl_monitor_i
(
   .core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .b1_tx_en_o, .b2_tx_en_o, .f_tx_off_o, .fa_tx_off_o, .act_req_o,
   .timer_expiry_o, .f8_to_f3_o, .line_en_o, .remote_loop_o,
   .local_loop_o, .host_tx_block_o, .line_d_ignore_o, .halt_tx_o,
   .ie_line_o, .q_bit_o, .q_pattern_o, .mf_synced_o
);

/* File: test/islc_line_model.sv */
// islc_line_model: behavioural line unit and echo channel.
// assumes: driven by bench task calls on the core clock.
`timescale 1ns/100ps
module islc_line_model
(
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       line_en_i,
   input  wire logic       act_req_i,
   output logic            in_f6_f7_o,
   output logic [5:0]      ev_o,
   output logic [4:0]      s_bits_o,
   output logic            echo_stb_o,
   output logic            echo_bit_o,
   output logic            mismatch_o
);
   // ev_o: {access, pkt_ok, q_taken, frame, bad, found}
   initial
   begin
      ev_o = 6'h00;
      s_bits_o = 5'h00;
      echo_stb_o = 1'b0;
      echo_bit_o = 1'b0;
      mismatch_o = 1'b0;
   end

   // active only with the line enabled and activation requested
   always_ff @(posedge core_clk_i or negedge rstn_i)
      if (!rstn_i)
         in_f6_f7_o <= 1'b0;
      else
         in_f6_f7_o <= line_en_i & act_req_i;

   task automatic pulse(input logic [5:0] v, input logic [4:0] s);
      @(posedge core_clk_i);
      ev_o <= v;
      s_bits_o <= s;
      @(posedge core_clk_i);
      ev_o <= 6'h00;
      s_bits_o <= ~s; // no stale s bits outside a frame
   endtask

   task automatic echo(input logic b);
      @(posedge core_clk_i);
      echo_stb_o <= 1'b1;
      echo_bit_o <= b;
      @(posedge core_clk_i);
      echo_stb_o <= 1'b0;
      echo_bit_o <= ~b;
   endtask

   task automatic mismatch(input logic m);
      @(posedge core_clk_i);
      mismatch_o <= m;
   endtask
endmodule // islc_line_model

/* File: test/islc_ctrl_tb.sv */
// islc_ctrl_tb: self-checking bench for the line interface control.
// assumes: islc_ctrl with its monitor bound, line model beside it.
`timescale 1ns/100ps
module islc_ctrl_tb;
   logic       core_clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   wire  [4:0] s_bits_i;
   wire        in_f6_f7_i, mf_found_i, mf_bad_i, mf_frame_i, q_taken_i;
   wire        echo_stb_i, echo_bit_i, pkt_ok_i, d_access_i, d_mismatch_i;
   logic [7:0] rdata_o;
   logic [3:0] ie_line_o, q_pattern_o;
   logic       b1_tx_en_o, b2_tx_en_o, f_tx_off_o, fa_tx_off_o, act_req_o;
   logic       timer_expiry_o, f8_to_f3_o, line_en_o, remote_loop_o;
   logic       local_loop_o, host_tx_block_o, line_d_ignore_o, halt_tx_o;
   logic       d_clear_o, q_bit_o, mf_synced_o, mf_irq_o;
   int         n_errors = 0;
   int         samples_checked = 0;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic       rd_seen = 1'b0;

   always #2 core_clk_i = ~core_clk_i;

   islc_ctrl islc_ctrl_i
   (
      .core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .in_f6_f7_i, .mf_found_i, .mf_bad_i, .mf_frame_i, .s_bits_i,
      .q_taken_i, .echo_stb_i, .echo_bit_i, .pkt_ok_i, .d_access_i,
      .d_mismatch_i, .b1_tx_en_o, .b2_tx_en_o, .f_tx_off_o, .fa_tx_off_o,
      .act_req_o, .timer_expiry_o, .f8_to_f3_o, .line_en_o,
      .remote_loop_o, .local_loop_o, .host_tx_block_o, .line_d_ignore_o,
      .halt_tx_o, .d_clear_o, .ie_line_o, .q_bit_o, .q_pattern_o,
      .mf_synced_o, .mf_irq_o
   );

   islc_line_model islc_line_model_i
   (
      .core_clk_i, .rstn_i, .line_en_i(line_en_o), .act_req_i(act_req_o),
      .in_f6_f7_o(in_f6_f7_i), .s_bits_o(s_bits_i),
      .ev_o({d_access_i, pkt_ok_i, q_taken_i, mf_frame_i, mf_bad_i,
             mf_found_i}),
      .echo_stb_o(echo_stb_i), .echo_bit_o(echo_bit_i),
      .mismatch_o(d_mismatch_i)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] x,
                        input logic [7:0] got);
      samples_checked++;
      if (got !== x)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, x, got);
      end
   endtask

   // read data lands one cycle after the strobe
   always @(posedge core_clk_i)
   begin
      if (rd_seen)
      begin
         e = exp_q.pop_front();
         check("rdata_o", e[7:0], rdata_o & e[15:8]);
      end
      rd_seen <= rd_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x,
                     input logic [7:0] m = 8'hFF);
      exp_q.push_back({m, x & m});
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
   endtask

   // a zero restarts the run; one short then exactly met
   task automatic count_run(input int need);
      islc_line_model_i.echo(1'b0);
      repeat (need - 1) islc_line_model_i.echo(1'b1);
      tick(3);
      check("d_clear_o", 8'h00, {7'h0, d_clear_o});
      islc_line_model_i.echo(1'b1);
      tick(3);
      check("d_clear_o", 8'h01, {7'h0, d_clear_o});
      islc_line_model_i.pulse(6'h20, 5'h00);
   endtask

   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      tick(90000);
      n_errors++;
      test_done();
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      logic [7:0] v;
      void'($urandom(32'h31436FE8));
      tick(10);
      rstn_i <= 1'b1;
      rd(islc_pkg::ADDR_PRIORITY, 8'h00);
      rd(islc_pkg::ADDR_MODE_ONE, 8'h00);
      rd(islc_pkg::ADDR_MODE_TWO, 8'h00);
      rd(islc_pkg::ADDR_MF_CTRL, 8'h00);
      rd(islc_pkg::ADDR_MF_STAT, 8'h40);
      rd(islc_pkg::ADDR_MF_QBUF, 8'h00);
      v = 8'($urandom);
      wr(islc_pkg::ADDR_PRIORITY, v);
      rd(islc_pkg::ADDR_PRIORITY, v & 8'h0F);
      wr(islc_pkg::ADDR_MODE_TWO, v);
      rd(islc_pkg::ADDR_MODE_TWO, v & 8'h7F);
      wr(islc_pkg::ADDR_MF_CTRL, 8'hFE);
      rd(islc_pkg::ADDR_MF_CTRL, 8'h1E);
      wr(8'hA5, 8'hFF);
      rd(8'hA5, 8'h00);
      // receiver on and settled before any activation request
      wr(islc_pkg::ADDR_MODE_ONE, 8'h40);
      tick(62500);
      for (int i = 0; i < 7; i++)
      begin
         v = 8'h40 | (8'h01 << i);
         wr(islc_pkg::ADDR_MODE_ONE, v);
         tick(3);
         check("mode_one", v, {1'b0, line_en_o, f8_to_f3_o,
            act_req_o, fa_tx_off_o, f_tx_off_o, b2_tx_en_o,
            b1_tx_en_o});
      end
      islc_line_model_i.mismatch(1'b1);
      for (int i = 0; i < 7; i++)
      begin
         v = 8'h01 << i;
         wr(islc_pkg::ADDR_MODE_TWO, v);
         tick(3);
         check("mode_two", {1'b0, v[6:3], ~(v[0] | v[2]), v[1], v[0]},
            {1'b0, ie_line_o, halt_tx_o, local_loop_o,
            remote_loop_o});
      end
      islc_line_model_i.mismatch(1'b0);
      for (int i = 0; i < 2; i++)
      begin
         v = (i == 0) ? 8'h00 : 8'($urandom_range(15));
         wr(islc_pkg::ADDR_PRIORITY, v);
         count_run(8 + 2 * v);
         islc_line_model_i.pulse(6'h10, 5'h00);
         count_run(10 + 2 * v);
         count_run(8 + 2 * v);
      end
      wr(islc_pkg::ADDR_MODE_ONE, 8'h50);
      wr(islc_pkg::ADDR_MF_QBUF, 8'h1A);
      wr(islc_pkg::ADDR_MF_CTRL, 8'h0F);
      tick(3);
      check("q_pattern_o", 8'h0F, {4'h0, q_pattern_o});
      islc_line_model_i.pulse(6'h01, 5'h00);
      tick(3);
      check("sync_irq", 8'h03, {6'h0, mf_synced_o, mf_irq_o});
      rd(islc_pkg::ADDR_MF_CTRL, 8'h8F);
      rd(islc_pkg::ADDR_MF_STAT, 8'h80);
      tick(3);
      check("irq_q", 8'h0A, {3'h0, mf_irq_o, q_pattern_o});
      islc_line_model_i.pulse(6'h04, 5'h15);
      islc_line_model_i.pulse(6'h08, 5'h00);
      tick(3);
      rd(islc_pkg::ADDR_MF_STAT, 8'h75);
      rd(islc_pkg::ADDR_MF_STAT, 8'h15);
      check("q_pattern_o", 8'h0A, {4'h0, q_pattern_o});
      repeat (3) islc_line_model_i.pulse(6'h02, 5'h00);
      tick(3);
      check("mf_synced_o", 8'h00, {7'h0, mf_synced_o});
      rd(islc_pkg::ADDR_MF_STAT, 8'h80, 8'hE0);
      islc_line_model_i.pulse(6'h01, 5'h00);
      tick(3);
      check("mf_synced_o", 8'h01, {7'h0, mf_synced_o});
      wr(islc_pkg::ADDR_MODE_ONE, 8'h40);
      tick(6);
      check("mf_synced_o", 8'h00, {7'h0, mf_synced_o});
      tick(2);
      test_done();
   end
endmodule // islc_ctrl_tb
